// ==== hw/rf_tx_check_and_status.sv ====
// send encoder check-sum, driver settings and status registers
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps

module rtcs_fifo #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         srst_in,
  // fill side
  input  wire logic [W-1:0] s_data_in,
  input  wire logic         s_valid_in,
  output logic              s_ready_out,
  // drain side
  output logic [W-1:0]      m_data_out,
  output logic              m_valid_out,
  input  wire logic         m_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    room;
    logic                    empty;
  } rtcs_fifo_st_t;

  rtcs_fifo_st_t s;
  rtcs_fifo_st_t n;
  logic          push;
  logic          pop;

  always_comb begin
    n    = s;
    push = s_valid_in && s.room;
    pop  = m_ready_in && !s.empty;
    if (push) begin
      n.mem[s.wp] = s_data_in;
      n.wp        = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
    end
    n.cnt   = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flags kept as flip-flops so ready and valid leave from registers
    n.room  = (n.cnt != (AW+1)'(DEPTH));
    n.empty = (n.cnt == '0);
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s       <= '0;
      s.room  <= 1'b1;
      s.empty <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign s_ready_out = s.room;
  assign m_valid_out = !s.empty;
  assign m_data_out  = s.mem[s.rp];

endmodule : rtcs_fifo

// Overview of operation
// - status receive bit is 1 while the receive decoder receives, else 0
// - status reports the 3-bit transceive phase 0 to 6; code 7 never shown
// - 16-bit custom seed in bits 31..16 of check config, resets to zero
// - with skip option set, first sent byte is left out of the check-sum
// - seed selector codes 0 to 5 load the six fixed seed values
// - selector 7 uses the custom seed; software never programs code 6
// - with 5-bit width only the low byte of the seed initialises the register
// - width bit 0 gives 16-bit check-sum, 1 gives 5-bit; resets to 0
// - complement bit 1 sends the inverted check-sum, 0 sends it unchanged
// - enable bit 1 appends a check-sum to the frame, 0 appends none
// - 3-bit driver1 clocking mode for carrier transitions in reader side
// - separate 3-bit driver1 clocking modes for modulated and plain carrier
// - 8-bit driver1 modulation depth, 0x00 none to 0xFF full
// - 8-bit driver1 carrier level, 0x00 none to 0xFF full, resets to 0xFF
// - status send bit is 1 while the encoder transmits, 0 when idle
module rf_tx_check_and_status
  import rtcs_pkg::*;
(
  // clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  srst_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // payload bytes into the encoder
  input  wire rtcs_byte_t  tx_byte_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  // encoded bytes toward the modulator
  output rtcs_byte_t       enc_byte_out,
  output logic             enc_valid_out,
  input  wire logic        enc_ready_in,
  // sequencer and receiver state
  input  wire logic [2:0]  seq_phase_in,
  input  wire logic        rx_busy_in,
  // driver1 reader side settings
  output logic [2:0]       driver1_transition_clocking_out,
  output logic [2:0]       driver1_modulated_clocking_out,
  output logic [2:0]       driver1_carrier_clocking_out,
  output logic [7:0]       driver1_modulation_depth_out,
  output logic [7:0]       driver1_carrier_level_out
);

  rtcs_top_st_t    s;
  rtcs_top_st_t    n;
  rtcs_byte_t      f_byte;
  logic [$bits(rtcs_byte_t)-1:0] f_raw;
  logic            f_valid;
  logic            f_pop;
  logic            can_load;
  logic [15:0]     seed_pick;
  logic [15:0]     seed_init;
  logic [15:0]     crc_tx;
  rtcs_drv_cfg_t   drv_w;
  rtcs_check_cfg_t chk_w;

  // one payload byte into the check-sum, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] d, input logic w5);
    logic [15:0] c;
    logic [4:0]  c5;
    logic        fb;
    c  = c_in;
    c5 = c_in[4:0];
    for (int i = 0; i < 8; i++) begin
      if (w5) begin
        fb = c5[0] ^ d[i];
        c5 = c5 >> 1;
        if (fb) begin
          c5 = c5 ^ POLY5;
        end
      end else begin
        fb = c[0] ^ d[i];
        c  = c >> 1;
        if (fb) begin
          c = c ^ POLY16;
        end
      end
    end
    crc_byte = w5 ? {11'h000, c5} : c;
  endfunction : crc_byte

  // four-byte buffer decouples the byte source from the encoder
  rtcs_fifo #(
    .W     ($bits(rtcs_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .s_data_in   (tx_byte_in),
    .s_valid_in  (tx_valid_in),
    .s_ready_out (tx_ready_out),
    .m_data_out  (f_raw),
    .m_valid_out (f_valid),
    .m_ready_in  (f_pop)
  );
  assign f_byte = rtcs_byte_t'(f_raw);

  assign drv_w = rtcs_drv_cfg_t'(reg_wdata_in);
  assign chk_w = rtcs_check_cfg_t'(reg_wdata_in);

  // seed selection
  always_comb begin
    unique case (rtcs_seed_sel_t'(s.ccfg.sel))
      SEL_ZERO:   seed_pick = SEED_ZERO;
      SEL_6363:   seed_pick = SEED_6363;
      SEL_A671:   seed_pick = SEED_A671;
      SEL_FFFF:   seed_pick = SEED_FFFF;
      SEL_0012:   seed_pick = SEED_0012;
      SEL_E012:   seed_pick = SEED_E012;
      // reserved code must not be programmed; it falls back to zero
      SEL_RFU:    seed_pick = SEED_ZERO;
      SEL_CUSTOM: seed_pick = s.ccfg.seed;
    endcase
    seed_init = s.ccfg.width5 ? {8'h00, seed_pick[7:0]} : seed_pick;
  end

  assign crc_tx   = s.ccfg.check_complement ? ~s.crc : s.crc;
  assign can_load = !s.ovalid || enc_ready_in;

  always_comb begin
    n     = s;
    f_pop = 1'b0;
    if (enc_ready_in) begin
      n.ovalid = 1'b0;
    end
    // settings are read live; software keeps them still during a frame
    unique case (s.mode)
      ENC_IDLE: begin
        if (f_valid) begin
          n.crc   = seed_init;
          n.first = 1'b1;
          n.mode  = ENC_DATA;
        end
      end
      ENC_DATA: begin
        if (f_valid && can_load) begin
          f_pop      = 1'b1;
          n.obyte    = f_byte;
          n.ovalid   = 1'b1;
          n.first    = 1'b0;
          if (!(s.first && s.ccfg.skip_first_byte_check)) begin
            n.crc = crc_byte(s.crc, f_byte.data, s.ccfg.width5);
          end
          n.obyte.last = f_byte.last && !s.ccfg.enable;
          if (f_byte.last) begin
            n.mode = s.ccfg.enable ? ENC_CRC_LO : ENC_IDLE;
          end
        end
      end
      ENC_CRC_LO: begin
        if (can_load) begin
          n.ovalid     = 1'b1;
          n.obyte.data = s.ccfg.width5 ? {3'h0, crc_tx[4:0]} : crc_tx[7:0];
          n.obyte.last = s.ccfg.width5;
          n.mode       = s.ccfg.width5 ? ENC_IDLE : ENC_CRC_HI;
        end
      end
      ENC_CRC_HI: begin
        if (can_load) begin
          n.ovalid     = 1'b1;
          n.obyte.data = crc_tx[15:8];
          n.obyte.last = 1'b1;
          n.mode       = ENC_IDLE;
        end
      end
      default: begin
        n.mode = ENC_IDLE;
      end
    endcase

    // status; a reserved phase code keeps the last legal one
    if (seq_phase_in != PHASE_RSVD) begin
      n.stat.phase = seq_phase_in;
    end
    n.stat.recv_active = rx_busy_in;
    n.stat.send_active = (n.mode != ENC_IDLE) || n.ovalid;
    n.stat.rsvd        = '0;

    // register writes
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        CHECK_ADDR: begin
          n.ccfg      = chk_w;
          n.ccfg.rsvd = '0;
        end
        DRV_ADDR: begin
          n.dcfg      = drv_w;
          n.dcfg.rsvd = '0;
        end
        default: begin
        end
      endcase
    end

    // read data stand for one cycle only
    n.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        STATUS_ADDR: n.rdata = s.stat;
        CHECK_ADDR:  n.rdata = s.ccfg;
        DRV_ADDR:    n.rdata = s.dcfg;
        default:     n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      s <= TOP_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_out                   = s.rdata;
  assign enc_byte_out                    = s.obyte;
  assign enc_valid_out                   = s.ovalid;
  assign driver1_transition_clocking_out = s.dcfg.driver1_transition_clocking;
  assign driver1_modulated_clocking_out  = s.dcfg.driver1_modulated_clocking;
  assign driver1_carrier_clocking_out    = s.dcfg.driver1_carrier_clocking;
  assign driver1_modulation_depth_out    = s.dcfg.driver1_modulation_depth;
  assign driver1_carrier_level_out       = s.dcfg.driver1_carrier_level;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  a_rx_status_follow: assert property (
    ##1 s.stat.recv_active == $past(rx_busy_in))
    else $error("receive status does not follow decoder");

  a_phase_legal_code: assert property (
    (seq_phase_in != PHASE_RSVD) |=> (s.stat.phase == $past(seq_phase_in)) && (s.stat.phase != PHASE_RSVD))
    else $error("phase status wrong or reserved");

  a_seed_reset_zero: assert property (
    $fell(srst_in) |-> (s.ccfg.seed == 16'h0000) && (s.ccfg.width5 == 1'b0))
    else $error("seed or width not cleared by reset");

  a_skip_first_byte: assert property (
    (s.mode == ENC_DATA) && f_pop && s.first && s.ccfg.skip_first_byte_check |=> s.crc == $past(s.crc))
    else $error("first byte entered check-sum");

  a_preset_fixed_seed: assert property (
    (s.mode == ENC_IDLE) && f_valid && (s.ccfg.sel == SEL_A671) && !s.ccfg.width5 |=> s.crc == SEED_A671)
    else $error("fixed seed not loaded");

  a_custom_seed_load: assert property (
    (s.mode == ENC_IDLE) && f_valid && (s.ccfg.sel == SEL_CUSTOM) && !s.ccfg.width5
    |=> s.crc == $past(s.ccfg.seed))
    else $error("custom seed not loaded");

  a_narrow_seed_byte: assert property (
    (s.mode == ENC_IDLE) && f_valid && s.ccfg.width5 |=> (s.crc[15:8] == 8'h00) && (s.mode == ENC_DATA))
    else $error("narrow seed uses high byte");

  a_narrow_one_tail: assert property (
    (s.mode == ENC_CRC_LO) && can_load && s.ccfg.width5
    |=> s.ovalid && s.obyte.last && (s.obyte.data[7:5] == 3'h0) && (s.mode == ENC_IDLE))
    else $error("narrow check-sum tail wrong");

  a_low_byte_sent: assert property (
    (s.mode == ENC_CRC_LO) && can_load && !s.ccfg.width5
    |=> s.ovalid && !s.obyte.last && (s.obyte.data == $past(s.ccfg.check_complement ? ~s.crc[7:0] : s.crc[7:0])))
    else $error("low check byte wrong");

  a_high_byte_sent: assert property (
    (s.mode == ENC_CRC_HI) && can_load |=> s.ovalid && s.obyte.last && (s.obyte.data == $past(crc_tx[15:8])))
    else $error("high check byte wrong");

  a_no_append_end: assert property (
    (s.mode == ENC_DATA) && f_pop && f_byte.last && !s.ccfg.enable |=> s.obyte.last && (s.mode == ENC_IDLE))
    else $error("check-sum appended while disabled");

  a_driver_fields_write: assert property (
    reg_wr_in && (reg_addr_in == DRV_ADDR)
    |=> {driver1_transition_clocking_out, driver1_modulated_clocking_out, driver1_carrier_clocking_out,
         driver1_modulation_depth_out} == $past(drv_w[24:8]))
    else $error("driver settings not taken");

  a_level_reset_full: assert property (
    $fell(srst_in) |-> driver1_carrier_level_out == 8'hff)
    else $error("carrier level reset wrong");

  a_send_busy_flag: assert property (
    ((s.mode != ENC_IDLE) || s.ovalid) |-> s.stat.send_active)
    else $error("send status low while encoder busy");

  a_send_idle_flag: assert property (
    (s.mode == ENC_IDLE) && !s.ovalid |-> !s.stat.send_active)
    else $error("send status high while idle");

endmodule : rf_tx_check_and_status

// ==== hw/rtcs_pkg.sv ====
// shared types and constants of the transmit check and status block
package rtcs_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned STATUS_IDX = 'h07;
  localparam int unsigned CHECK_IDX  = 'h12;
  localparam int unsigned DRV_IDX    = 'h16;
  localparam logic [7:0]  STATUS_ADDR = 8'(STATUS_IDX * 4);
  localparam logic [7:0]  CHECK_ADDR  = 8'(CHECK_IDX * 4);
  localparam logic [7:0]  DRV_ADDR    = 8'(DRV_IDX * 4);

  // seed selector codes and seed values
  typedef enum logic [2:0] {
    SEL_ZERO   = 3'h0,
    SEL_6363   = 3'h1,
    SEL_A671   = 3'h2,
    SEL_FFFF   = 3'h3,
    SEL_0012   = 3'h4,
    SEL_E012   = 3'h5,
    SEL_RFU    = 3'h6,
    SEL_CUSTOM = 3'h7
  } rtcs_seed_sel_t;
  localparam logic [15:0] SEED_ZERO = 16'h0000;
  localparam logic [15:0] SEED_6363 = 16'h6363;
  localparam logic [15:0] SEED_A671 = 16'ha671;
  localparam logic [15:0] SEED_FFFF = 16'hffff;
  localparam logic [15:0] SEED_0012 = 16'h0012;
  localparam logic [15:0] SEED_E012 = 16'he012;

  // check-sum polynomials, reflected for lsb-first processing
  localparam logic [15:0] POLY16 = 16'h8408;
  localparam logic [4:0]  POLY5  = 5'h12;

  // transceive phase codes
  localparam logic [2:0] PHASE_IDLE = 3'h0;
  localparam logic [2:0] PHASE_RSVD = 3'h7;

  // data path
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              last;
  } rtcs_byte_t;

  // register layouts
  typedef struct packed {
    logic [15:0] seed;
    logic [8:0]  rsvd;
    logic        skip_first_byte_check;
    logic [2:0]  sel;
    logic        width5;
    logic        check_complement;
    logic        enable;
  } rtcs_check_cfg_t;
  typedef struct packed {
    logic [6:0] rsvd;
    logic [2:0] driver1_transition_clocking;
    logic [2:0] driver1_modulated_clocking;
    logic [2:0] driver1_carrier_clocking;
    logic [7:0] driver1_modulation_depth;
    logic [7:0] driver1_carrier_level;
  } rtcs_drv_cfg_t;
  typedef struct packed {
    logic [26:0] rsvd;
    logic        send_active;
    logic        recv_active;
    logic [2:0]  phase;
  } rtcs_status_t;

  localparam logic [7:0]    CARRIER_LEVEL_RST = 8'hff;
  localparam rtcs_drv_cfg_t DRV_RST = '{driver1_carrier_level: CARRIER_LEVEL_RST, default: '0};

  // send encoder states
  typedef enum logic [3:0] {
    ENC_IDLE   = 4'h1,
    ENC_DATA   = 4'h2,
    ENC_CRC_LO = 4'h4,
    ENC_CRC_HI = 4'h8
  } rtcs_enc_t;

  typedef struct packed {
    rtcs_enc_t       mode;
    logic [15:0]     crc;
    logic            first;
    rtcs_byte_t      obyte;
    logic            ovalid;
    rtcs_check_cfg_t ccfg;
    rtcs_drv_cfg_t   dcfg;
    rtcs_status_t    stat;
    logic [31:0]     rdata;
  } rtcs_top_st_t;
  localparam rtcs_top_st_t TOP_RST = '{mode: ENC_IDLE, dcfg: DRV_RST, default: '0};

endpackage : rtcs_pkg

// ==== test/rtcs_sink.sv ====
// far-side model taking encoded bytes toward the modulator
`timescale 1ns/100ps

module rtcs_sink
  import rtcs_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  // encoded byte stream
  input  wire rtcs_byte_t byte_in,
  input  wire logic       valid_in,
  input  wire logic       stall_in,
  output logic            ready_out
);
  rtcs_byte_t q[$];

  // stall lets the bench play a slow modulator
  assign ready_out = !stall_in;

  always @(posedge sys_clk_in) begin
    if (srst_in) begin
      q.delete();
    end else if (valid_in && ready_out) begin
      q.push_back(byte_in);
    end
  end
endmodule : rtcs_sink

// ==== test/tb_top.sv ====
// self-checking bench of the transmit check and status block
`timescale 1ns/100ps

module tb_top
  import rtcs_pkg::*;
;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic [7:0]  addr  = '0;
  logic [31:0] wd    = '0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [31:0] rdata;
  rtcs_byte_t  txb   = '0;
  logic        tx_v  = 1'b0;
  logic        tx_rdy;
  rtcs_byte_t  eb;
  logic        ev;
  logic        er;
  logic [2:0]  ph    = '0;
  logic        rxb   = 1'b0;
  logic        stall = 1'b0;
  logic [2:0]  o_tr, o_mo, o_cw;
  logic [7:0]  o_dp, o_lv;
  logic [7:0]  pl[6] = '{8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab};
  int          error_cnt = 0;
  int          checked = 0;

  always #2 clk = ~clk;

  rf_tx_check_and_status u_dut (
    .sys_clk_in(clk), .srst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_byte_in(txb), .tx_valid_in(tx_v), .tx_ready_out(tx_rdy),
    .enc_byte_out(eb), .enc_valid_out(ev), .enc_ready_in(er), .seq_phase_in(ph), .rx_busy_in(rxb),
    .driver1_transition_clocking_out(o_tr), .driver1_modulated_clocking_out(o_mo),
    .driver1_carrier_clocking_out(o_cw), .driver1_modulation_depth_out(o_dp),
    .driver1_carrier_level_out(o_lv)
  );

  rtcs_sink u_sink (
    .sys_clk_in(clk), .srst_in(rst), .byte_in(eb), .valid_in(ev), .stall_in(stall), .ready_out(er)
  );

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_byte(input rtcs_byte_t got, input rtcs_byte_t exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic final_report();
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // leading edge wait keeps strobes from being set and cleared in one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // data stand only in the cycle after the strobe edge
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d, input bit five);
    for (int i = 0; i < 8; i++) begin
      if (five) c[4:0] = (c[0] ^ d[i]) ? ((c[4:0] >> 1) ^ POLY5) : (c[4:0] >> 1);
      else c = (c[0] ^ d[i]) ? ((c >> 1) ^ POLY16) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      txb <= {pl[i], 1'(i == n - 1)};
      tx_v <= 1'b1;
      do @(posedge clk); while (tx_rdy !== 1'b1);
    end
    tx_v <= 1'b0;
  endtask : send

  task automatic t_reset();
    logic [31:0] r;
    rd_reg(CHECK_ADDR, r);
    chk_word(r, 32'h0000_0000);
    rd_reg(DRV_ADDR, r);
    chk_word(r, 32'h0000_00ff);
    chk_word({7'h0, o_tr, o_mo, o_cw, o_dp, o_lv}, 32'h0000_00ff);
  endtask : t_reset

  task automatic t_regs();
    logic [31:0] r;
    logic [31:0] e;
    e = {7'h0, 3'h5, 3'h3, 3'h6, 8'ha5, 8'hc3};
    wr_reg(DRV_ADDR, e | 32'hfe00_0000);
    rd_reg(DRV_ADDR, r);
    chk_word(r, e);
    chk_word({7'h0, o_tr, o_mo, o_cw, o_dp, o_lv}, e);
    wr_reg(CHECK_ADDR, 32'hbeef_ffff);
    rd_reg(CHECK_ADDR, r);
    chk_word(r, 32'hbeef_007f);
    wr_reg(STATUS_ADDR, 32'hffff_ffff);
    rd_reg(STATUS_ADDR, r);
    chk_word(r, 32'h0000_0000);
    rd_reg(8'h04, r);
    chk_word(r, 32'h0000_0000);
  endtask : t_regs

  // reset in mid-run after the settings were changed
  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
  endtask : t_rerst

  task automatic t_status();
    logic [31:0] r;
    for (int p = 0; p < 7; p++) begin
      ph <= 3'(p);
      rxb <= p[0];
      rd_reg(STATUS_ADDR, r);
      chk_word(r, {27'h0, 1'b0, p[0], 3'(p)});
    end
    ph <= PHASE_RSVD;
    rxb <= 1'b0;
    rd_reg(STATUS_ADDR, r);
    chk_word(r, 32'h0000_0006);
    ph <= PHASE_IDLE;
  endtask : t_status

  task automatic run_frame(input logic [31:0] cfg, input int n, input bit hold);
    logic [15:0] seeds[8];
    logic [15:0] c;
    logic [31:0] r;
    rtcs_byte_t  exp_q[$];
    rtcs_byte_t  got;
    seeds = '{SEED_ZERO, SEED_6363, SEED_A671, SEED_FFFF, SEED_0012, SEED_E012, SEED_ZERO, cfg[31:16]};
    c = seeds[cfg[5:3]];
    if (cfg[2]) c = {8'h0, c[7:0]};
    for (int i = 0; i < n; i++) begin
      if (!(cfg[6] && i == 0)) c = crc_step(c, pl[i], cfg[2]);
      exp_q.push_back({pl[i], 1'(!cfg[0] && i == n - 1)});
    end
    if (cfg[1]) c = ~c;
    if (cfg[0] && cfg[2]) exp_q.push_back({3'h0, c[4:0], 1'b1});
    if (cfg[0] && !cfg[2]) begin
      exp_q.push_back({c[7:0], 1'b0});
      exp_q.push_back({c[15:8], 1'b1});
    end
    wr_reg(CHECK_ADDR, cfg);
    if (hold) begin
      stall <= 1'b1;
      fork
        send(n);
      join_none
      repeat (20) @(posedge clk);
      chk_word({31'h0, tx_rdy}, 32'h0);
      rd_reg(STATUS_ADDR, r);
      chk_word(r, 32'h0000_0010);
      stall <= 1'b0;
      wait fork;
    end else begin
      send(n);
    end
    for (int k = 0; k < 60 && u_sink.q.size() < exp_q.size(); k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk_word(32'(u_sink.q.size()), 32'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < u_sink.q.size(); i++) begin
      got = u_sink.q[i];
      // upper bits of a 5-bit check byte are not defined
      if (cfg[0] && cfg[2] && i == exp_q.size() - 1) got.data[7:5] = 3'h0;
      chk_byte(got, exp_q[i]);
    end
    u_sink.q.delete();
    rd_reg(STATUS_ADDR, r);
    chk_word(r, 32'h0000_0000);
  endtask : run_frame

  task automatic t_crc();
    for (int s = 0; s < 8; s++) begin
      if (s != 6) run_frame({16'h5a3c, 10'h0, 3'(s), 3'b001}, 3, 1'b0);
    end
    run_frame(32'h0000_000b, 4, 1'b0);
    run_frame(32'h0000_0025, 2, 1'b0);
    run_frame(32'h1234_003f, 3, 1'b0);
    run_frame(32'h0000_0059, 4, 1'b0);
    run_frame(32'h0000_0040, 6, 1'b1);
  endtask : t_crc

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_rerst();
    t_status();
    t_crc();
    final_report();
  end

  // whole run needs a few hundred cycles
  initial begin
    #40000;
    error_cnt++;
    final_report();
  end
endmodule : tb_top
